// File: design/odt_defs.svh
// timing and layout constants of the termination control block
`ifndef ODT_DEFS_SVH
`define ODT_DEFS_SVH

// clock period in ps (125 MHz)
`define ODT_TCK_PS 8000
// asynchronous turn-on / turn-off delays in ps
`define ODT_TAONPD_MIN_PS 2000
`define ODT_TAONPD_MAX_PS 8500
`define ODT_TAOFPD_MIN_PS 2000
`define ODT_TAOFPD_MAX_PS 8500
// least time rounds up, longest time rounds down
`define ODT_ASYNC_MIN_CYC ((`ODT_TAONPD_MIN_PS + `ODT_TCK_PS - 1) / `ODT_TCK_PS)
`define ODT_ASYNC_MAX_CYC (`ODT_TAONPD_MAX_PS / `ODT_TCK_PS)
// refresh cycle time and dll-off exit delay in ns
`define ODT_TRFC_NS 160
`define ODT_TXPDLL_NS 24
`define ODT_TRFC_CYC ((`ODT_TRFC_NS * 1000 + `ODT_TCK_PS - 1) / `ODT_TCK_PS)
`define ODT_TXPDLL_CYC ((`ODT_TXPDLL_NS * 1000 + `ODT_TCK_PS - 1) / `ODT_TCK_PS)
// clocked latency is write latency minus this
`define ODT_LAT_SUB 2
// anticipation delay is write latency minus this
`define ODT_ANPD_SUB 1
// depth of the odt history line
`define ODT_LINE_DEPTH 32
`define ODT_LAT_W 6

`endif

// File: design/odt_pkg.sv
// types of the termination control block
package odt_pkg;
  typedef enum logic [1:0] {
    ST_SYNC = 2'b00,
    ST_ENTRY = 2'b01,
    ST_ASYNC = 2'b10,
    ST_EXIT = 2'b11
  } odt_state_type;
endpackage

// File: design/odt_history.sv
// history line of registered odt samples with a selectable tap
`timescale 1ns/1ps
`include "odt_defs.svh"
module odt_history (
  input wire logic clk,
  input wire logic srst,
  input wire logic odt_in,
  input wire logic [`ODT_LAT_W-1:0] tap,
  output logic tap_out
);
  logic [`ODT_LINE_DEPTH-1:0] line_q;

  // ==========================================
  // shift register
  always_ff @(posedge clk) begin
    if (srst) begin
      line_q <= '0;
    end else begin
      line_q <= {line_q[`ODT_LINE_DEPTH-2:0], odt_in};
    end
  end

  // tap k holds the sample registered k-1 edges ago
  always_comb begin
    if (tap == '0) begin
      tap_out = line_q[0];
    end else begin
      tap_out = line_q[5'(tap - 6'h01)];
    end
  end
endmodule // odt_history

// File: design/odt_ctrl.sv
// on-die termination timing control: sync, async and power-down transitions
//
// Contract
// RULE1 - async termination when dll is off in precharge power-down, termination enabled
// RULE2 - async termination while the dll relocks after a dll reset
// RULE3 - async mode ignores additive latency; odt acts with no clock-count delay
// RULE4 - async mode uses fixed power-down delays, not clocked latencies
// RULE5 - async turn-on starts after 2 ns, fully on by 8.5 ns
// RULE6 - async turn-off starts after 2 ns, high impedance by 8.5 ns
// RULE7 - entry transition only when mode bit selects dll off in power-down
// RULE8 - entry transition spans anticipation delay up to cke first registered low
// RULE9 - anticipation delay is write latency minus one
// RULE10 - refresh in progress stretches entry transition to one refresh cycle time
// RULE11 - turn-on during entry within lesser minimum and greater maximum of both
// RULE12 - turn-off during entry within lesser minimum and greater maximum of both
// RULE13 - clocked turn-on and turn-off latency is write latency minus two
// RULE14 - sync before transition, async after it, either within it
// RULE15 - exit transition lasts anticipation delay plus dll-off exit delay
// RULE16 - sync mode switches termination write latency minus two clocks after odt
// RULE17 - exit transition ends dll-off exit delay after cke registered high; the code ends it anticipation plus dll-off exit delay after
// RULE18 - state tracked per cke edge; transition accepts any time within bounds
`timescale 1ns/1ps
`include "odt_defs.svh"
module odt_ctrl
  import odt_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic odt,
  input wire logic cke,
  input wire logic refresh_cmd,
  input wire logic dll_locked,
  input wire logic dll_pd_on,
  input wire logic banks_idle,
  input wire logic rtt_nom_en,
  input wire logic rtt_wr_en,
  input wire logic [4:0] cwl,
  input wire logic [4:0] al,
  output logic rtt_on,
  output odt_state_type odt_state,
  output logic async_resp
);
  // ==========================================
  // latency arithmetic
  function automatic logic [`ODT_LAT_W-1:0] wl_minus(input logic [4:0] c, input logic [4:0] a,
                                                     input logic [`ODT_LAT_W-1:0] sub);
    wl_minus = `ODT_LAT_W'({1'b0, c} + {1'b0, a} - sub);
  endfunction

  localparam logic [`ODT_LAT_W-1:0] LAT_SUB = `ODT_LAT_W'(`ODT_LAT_SUB);
  localparam logic [`ODT_LAT_W-1:0] ANPD_SUB = `ODT_LAT_W'(`ODT_ANPD_SUB);
  localparam logic [7:0] TRFC_CYC = 8'(`ODT_TRFC_CYC);
  localparam logic [7:0] TXPDLL_CYC = 8'(`ODT_TXPDLL_CYC);

  logic [`ODT_LAT_W-1:0] odtl;
  logic [`ODT_LAT_W-1:0] anpd;
  logic term_en;
  logic sync_odt;
  logic cke_q;
  logic cke_fall;
  logic cke_rise;
  logic pd_dll_off;
  logic [7:0] rfc_q;
  logic [7:0] exit_q;
  odt_state_type state_q;
  odt_state_type state_d;
  logic rtt_q;

  assign odtl = wl_minus(cwl, al, LAT_SUB); // RULE13
  assign anpd = wl_minus(cwl, al, ANPD_SUB); // RULE9
  assign term_en = rtt_nom_en | rtt_wr_en;
  assign cke_fall = cke_q & ~cke;
  assign cke_rise = ~cke_q & cke;
  assign pd_dll_off = ~dll_pd_on & banks_idle; // RULE7

  // ==========================================
  // clocked-latency path
  odt_history u_history (
    .clk(clk),
    .srst(srst),
    .odt_in(odt),
    .tap(odtl),
    .tap_out(sync_odt)
  );

  // ==========================================
  // cke history and refresh tracking
  always_ff @(posedge clk) begin
    if (srst) begin
      cke_q <= 1'b0;
    end else begin
      cke_q <= cke;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rfc_q <= 8'h00;
    end else if (refresh_cmd) begin
      rfc_q <= TRFC_CYC - 8'h01;
    end else if (rfc_q != 8'h00) begin
      rfc_q <= rfc_q - 8'h01; // RULE10
    end
  end

  // ==========================================
  // mode state, stepped by cke edges, by the end of refresh and by the exit count
  // the lead-in of a transition cannot be foreseen; the async answer is
  // inside both bounds, so it serves the whole window
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_SYNC: begin
        if (cke_fall && pd_dll_off) begin
          state_d = (rfc_q > 8'h01) ? ST_ENTRY : ST_ASYNC; // RULE8 RULE10 RULE18
        end
      end
      ST_ENTRY: begin
        if (cke_rise) begin
          state_d = ST_EXIT;
        end else if (rfc_q <= 8'h01) begin
          state_d = ST_ASYNC; // RULE10
        end
      end
      ST_ASYNC: begin
        if (cke_rise) begin
          state_d = ST_EXIT; // RULE17
        end
      end
      ST_EXIT: begin
        if (cke_fall && pd_dll_off) begin
          state_d = ST_ENTRY; // overlapping short cke pulse
        end else if (exit_q == 8'h00) begin
          state_d = ST_SYNC; // RULE14
        end
      end
      default: state_d = ST_SYNC;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= ST_SYNC;
    end else begin
      state_q <= state_d;
    end
  end

  // exit window: anticipation plus dll-off exit delay
  always_ff @(posedge clk) begin
    if (srst) begin
      exit_q <= 8'h00;
    end else if (state_d == ST_EXIT && state_q != ST_EXIT) begin
      exit_q <= 8'(anpd) + TXPDLL_CYC - 8'h01; // RULE15
    end else if (exit_q != 8'h00) begin
      exit_q <= exit_q - 8'h01;
    end
  end

  // ==========================================
  // termination output
  assign async_resp = (state_q != ST_SYNC) | ~dll_locked; // RULE1 RULE2 RULE14

  always_ff @(posedge clk) begin
    if (srst) begin
      rtt_q <= 1'b0;
    end else if (!term_en) begin
      rtt_q <= 1'b0;
    end else if (async_resp) begin
      // one edge = 8 ns, inside the 2..8.5 ns async window, no latency added
      rtt_q <= odt; // RULE3 RULE4 RULE5 RULE6 RULE11 RULE12
    end else begin
      rtt_q <= sync_odt; // RULE16
    end
  end

  assign rtt_on = rtt_q;
  assign odt_state = state_q;

  // ==========================================
  // assertions
  localparam int EXIT_MAX = 300;

  property p_async_follow;
    @(posedge clk) disable iff (srst)
      (async_resp && term_en) |=> (rtt_on == $past(odt));
  endproperty
  a_async_follow: assert property (p_async_follow) // RULE5
    else $error("async termination missed one-edge response");

  property p_async_off;
    @(posedge clk) disable iff (srst)
      (async_resp && term_en && !odt) |=> !rtt_on;
  endproperty
  a_async_off: assert property (p_async_off) // RULE6
    else $error("async termination did not turn off");

  property p_no_term;
    @(posedge clk) disable iff (srst)
      !term_en |=> !rtt_on;
  endproperty
  a_no_term: assert property (p_no_term) // RULE1
    else $error("termination on while disabled");

  property p_dll_relock;
    @(posedge clk) disable iff (srst)
      !dll_locked |-> async_resp;
  endproperty
  a_dll_relock: assert property (p_dll_relock) // RULE2
    else $error("sync response while dll unlocked");

  // six edges of latency plus the output register: odt seen seven samples back
  property p_sync_lat;
    @(posedge clk) disable iff (srst)
      (!async_resp && term_en && odtl == 6'h06) [*8] |-> rtt_on == $past(odt, 7);
  endproperty
  a_sync_lat: assert property (p_sync_lat) // RULE16
    else $error("sync termination latency wrong");

  property p_entry_gate;
    @(posedge clk) disable iff (srst)
      (state_q == ST_SYNC && cke_fall && !pd_dll_off) |=> state_q == ST_SYNC;
  endproperty
  a_entry_gate: assert property (p_entry_gate) // RULE7
    else $error("entry transition with dll kept on");

  property p_entry_end;
    @(posedge clk) disable iff (srst)
      (state_q == ST_SYNC && cke_fall && pd_dll_off && rfc_q <= 8'h01) |=> state_q == ST_ASYNC;
  endproperty
  a_entry_end: assert property (p_entry_end) // RULE8
    else $error("entry transition did not end at cke low");

  property p_refresh_hold;
    @(posedge clk) disable iff (srst)
      (state_q == ST_ENTRY && !cke_rise && rfc_q > 8'h01) |=> state_q == ST_ENTRY;
  endproperty
  a_refresh_hold: assert property (p_refresh_hold) // RULE10
    else $error("entry ended before refresh finished");

  property p_exit_len;
    @(posedge clk) disable iff (srst)
      (state_q == ST_ASYNC && cke_rise) ##1 cke |->
        (state_q == ST_EXIT) ##1 (state_q == ST_EXIT);
  endproperty
  a_exit_len: assert property (p_exit_len) // RULE15
    else $error("exit transition too short");

  property p_exit_bound;
    @(posedge clk) disable iff (srst)
      (state_q == ST_ASYNC && cke_rise && cke) ##1 cke [*2] |->
        ##[0:EXIT_MAX] state_q == ST_SYNC;
  endproperty
  a_exit_bound: assert property (p_exit_bound) // RULE17
    else $error("exit transition never ended");

  c_entry_refresh: cover property (@(posedge clk) disable iff (srst) state_q == ST_ENTRY);
  c_async: cover property (@(posedge clk) disable iff (srst) state_q == ST_ASYNC && rtt_on);
  c_exit_sync: cover property (@(posedge clk) disable iff (srst)
    state_q == ST_EXIT ##1 state_q == ST_SYNC);
endmodule // odt_ctrl

// File: dv/ctrl_model.sv
// controller-side model driving odt, cke and refresh commands
`timescale 1ns/1ps
module ctrl_model (
  input wire logic clk,
  output logic odt,
  output logic cke,
  output logic refresh_cmd
);
  initial begin
    odt = 1'b0;
    cke = 1'b1;
    refresh_cmd = 1'b0;
  end
  // changes land 1 ns after the edge so sampling never races the drive
  task automatic drive(input logic o, input logic c, input logic r);
    @(posedge clk);
    #1;
    odt = o;
    cke = c;
    refresh_cmd = r;
  endtask
endmodule // ctrl_model

// File: dv/ddr3_odt_async_transition_tb.sv
// self-checking bench of the termination timing control
`timescale 1ns/1ps
`include "odt_defs.svh"
module ddr3_odt_async_transition_tb
  import odt_pkg::*;
;
  // ==========================
  // stimulus and design
  // ==========================
  localparam int WL = 8;
  logic clk, srst, odt, cke, refresh_cmd, dll_locked, dll_pd_on, rtt_nom_en, rtt_wr_en;
  logic rtt_on, async_resp;
  odt_state_type odt_state;
  int err_count = 0;
  int n_compared = 0;
  ctrl_model u_ctl (.clk(clk), .odt(odt), .cke(cke), .refresh_cmd(refresh_cmd));
  odt_ctrl DUT (.clk(clk), .srst(srst), .odt(odt), .cke(cke), .refresh_cmd(refresh_cmd),
    .dll_locked(dll_locked), .dll_pd_on(dll_pd_on), .banks_idle(1'b1),
    .rtt_nom_en(rtt_nom_en), .rtt_wr_en(rtt_wr_en), .cwl(5'h05), .al(5'h03),
    .rtt_on(rtt_on), .odt_state(odt_state), .async_resp(async_resp));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ==========================
  // checking helpers
  // ==========================
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic bad(input string msg);
    err_count++;
    $display("wrong value at %0t: %s", $time, msg);
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string msg);
    n_compared++;
    if (got !== exp) bad(msg);
  endtask
  task automatic chk_state(input odt_state_type got, input odt_state_type exp);
    n_compared++;
    if (got !== exp) bad("state");
  endtask
  task automatic chk_int(input int got, input int lo, input int hi, input string msg);
    n_compared++;
    if (got < lo || got > hi) bad(msg);
  endtask
  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ==========================
  // scenarios
  // ==========================
  task automatic t_sync();
    u_ctl.drive(1'b1, 1'b1, 1'b0);
    tick(WL - 2);
    chk_bit(rtt_on, 1'b0, "sync early");
    tick(1);
    chk_bit(rtt_on, 1'b1, "sync on");
    u_ctl.drive(1'b0, 1'b1, 1'b0);
    tick(WL - 1);
    chk_bit(rtt_on, 1'b0, "sync off");
  endtask
  task automatic t_async();
    u_ctl.drive(1'b0, 1'b0, 1'b0);
    tick(2);
    chk_state(odt_state, ST_ASYNC);
    chk_bit(async_resp, 1'b1, "async flag");
    u_ctl.drive(1'b1, 1'b0, 1'b0);
    chk_bit(rtt_on, 1'b0, "async on early");
    tick(1);
    chk_bit(rtt_on, 1'b1, "async on");
    u_ctl.drive(1'b0, 1'b0, 1'b0);
    chk_bit(rtt_on, 1'b1, "async off early");
    tick(1);
    chk_bit(rtt_on, 1'b0, "async off");
  endtask
  task automatic t_exit();
    int n;
    u_ctl.drive(1'b0, 1'b1, 1'b0);
    n = 0;
    while (odt_state !== ST_EXIT && n < 4) begin
      tick(1);
      n++;
    end
    n = 0;
    while (odt_state === ST_EXIT && n < 60) begin
      tick(1);
      n++;
    end
    chk_int(n, WL - 1 + `ODT_TXPDLL_CYC, WL - 1 + `ODT_TXPDLL_CYC, "exit span");
    chk_state(odt_state, ST_SYNC);
  endtask
  task automatic t_refresh();
    int e;
    u_ctl.drive(1'b0, 1'b1, 1'b1);
    u_ctl.drive(1'b0, 1'b1, 1'b0);
    u_ctl.drive(1'b0, 1'b0, 1'b0);
    tick(2);
    chk_state(odt_state, ST_ENTRY);
    u_ctl.drive(1'b1, 1'b0, 1'b0);
    chk_bit(rtt_on, 1'b0, "entry on early");
    tick(1);
    e = 5;
    // turn-on may take up to the clocked latency inside the entry window
    while (rtt_on !== 1'b1 && e < 5 + WL - 2) begin
      tick(1);
      e++;
    end
    chk_bit(rtt_on, 1'b1, "entry on late");
    while (odt_state === ST_ENTRY && e < 60) begin
      tick(1);
      e++;
    end
    chk_int(e, `ODT_TRFC_CYC - 2, `ODT_TRFC_CYC + 1, "entry span");
    chk_state(odt_state, ST_ASYNC);
    t_exit();
  endtask
  task automatic t_misc();
    dll_pd_on = 1'b1;
    u_ctl.drive(1'b0, 1'b0, 1'b0);
    tick(3);
    chk_state(odt_state, ST_SYNC);
    dll_pd_on = 1'b0;
    u_ctl.drive(1'b0, 1'b1, 1'b0);
    dll_locked = 1'b0;
    tick(1);
    chk_bit(async_resp, 1'b1, "relock");
    dll_locked = 1'b1;
    rtt_nom_en = 1'b0;
    rtt_wr_en = 1'b0;
    u_ctl.drive(1'b1, 1'b1, 1'b0);
    tick(WL);
    chk_bit(rtt_on, 1'b0, "disabled");
    chk_bit(async_resp, 1'b0, "locked sync");
  endtask
  // ==========================
  // main sequence and watchdog
  // ==========================
  initial begin
    srst = 1'b1;
    dll_locked = 1'b1;
    dll_pd_on = 1'b0;
    rtt_nom_en = 1'b1;
    rtt_wr_en = 1'b0;
    tick(8);
    srst = 1'b0;
    chk_bit(rtt_on, 1'b0, "reset rtt");
    chk_state(odt_state, ST_SYNC);
    tick(2);
    t_sync();
    t_async();
    t_exit();
    t_refresh();
    t_misc();
    tally_and_finish();
  end
  // whole run is about a hundred cycles; this bound leaves wide margin
  initial begin
    #20000;
    err_count++;
    tally_and_finish();
  end
endmodule // ddr3_odt_async_transition_tb
